// >>> hdl/ehbp_pkg.sv
// Constants shared by the host bus port of the Ethernet controller.
// Assumes a 40 MHz device clock; host strobes arrive synchronous to it.
package ehbp_pkg;
   // ---------------------------------------------------------------
   // Widths
   // ---------------------------------------------------------------
   localparam int HOST_W  = 16;          // Host data bus
   localparam int WORD_W  = 32;          // Internal data paths
   localparam int ADDR_W  = 7;           // Host word address
   localparam int SRC_W   = 4;           // Interrupt sources
   // ---------------------------------------------------------------
   // Word address map
   // ---------------------------------------------------------------
   localparam logic [6:0] ADDR_CTRL    = 7'h20; // Control bits
   localparam logic [6:0] ADDR_IRQ_EN  = 7'h21; // Source enables
   localparam logic [6:0] ADDR_IRQ_STS = 7'h22; // Sticky, write one to clear
   localparam logic [6:0] ADDR_HOLDOFF = 7'h23; // Deassertion interval
   localparam logic [6:0] ADDR_TX_CMD  = 7'h24; // Frame end command
   localparam logic [6:0] ADDR_STATUS  = 7'h25; // Port state
   localparam logic [6:0] ADDR_MAC_LO  = 7'h28; // First MAC register word
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int CTRL_BIG_END  = 0;     // Byte-swap data words
   localparam int CTRL_IRQ_POL  = 1;     // 1: active high
   localparam int CTRL_IRQ_PP   = 2;     // 1: push-pull, 0: open-drain
   localparam int CTRL_LOW_PWR  = 3;     // Enter reduced power
   localparam int SRC_RX_AVAIL  = 0;
   localparam int SRC_TX_OVF    = 1;
   localparam int SRC_RX_UNDER  = 2;
   localparam int SRC_MAC       = 3;
   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [15:0] CTRL_RST    = 16'h0000;
   localparam logic [3:0]  IRQ_EN_RST  = 4'h0;
   localparam logic [7:0]  HOLDOFF_RST = 8'h00;
   // ---------------------------------------------------------------
   // Sizes and timing
   // ---------------------------------------------------------------
   localparam int MAC_TX_BYTES   = 2048;  // Store-and-forward buffer
   localparam int MAC_RX_BYTES   = 128;   // Behind the receive FIFO
   localparam int CLK_MHZ        = 40;
   localparam int HOLDOFF_UNIT_NS = 10000; // One holdoff step
   localparam int HOLDOFF_UNIT_CYC = (HOLDOFF_UNIT_NS * CLK_MHZ) / 1000;
   localparam logic [12:0] TX_BYTES_PER_WORD = 13'h0004;
endpackage : ehbp_pkg

// >>> hdl/ehbp_skid_buf.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock; a stalled drain side never loses a word.
`timescale 1ns/1ps
`default_nettype none
module ehbp_skid_buf #(
   parameter int W = 32
) (
   input  wire logic         mclk,
   input  wire logic         arst_n,
   input  wire logic [W-1:0] inData,
   input  wire logic         inValid,
   output logic              inReady,
   output logic [W-1:0]      outData,
   output logic              outValid,
   input  wire logic         outReady
);
   logic [W-1:0] slot0_r;
   logic [W-1:0] slot1_r;
   logic [1:0]   count_r;
   logic         doPush;
   logic         doPop;

   // ---------------------------------------------------------------
   // Handshakes
   // ---------------------------------------------------------------
   assign inReady  = (count_r != 2'd2);
   assign outValid = (count_r != 2'd0);
   assign outData  = slot0_r;
   assign doPush   = inValid & inReady;
   assign doPop    = outValid & outReady;

   // Slot 0 is always the head, so the output stays a flop
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         slot0_r <= '0;
         slot1_r <= '0;
         count_r <= 2'd0;
      end else begin
         if (doPop) begin
            slot0_r <= (count_r == 2'd2) ? slot1_r : inData;
         end else if (doPush && count_r == 2'd0) begin
            slot0_r <= inData;
         end
         if (doPush && ((count_r == 2'd1 && !doPop) || (count_r == 2'd2))) begin
            slot1_r <= inData;
         end
         count_r <= count_r + {1'b0, doPush} - {1'b0, doPop};
      end
   end
endmodule : ehbp_skid_buf
`default_nettype wire

// >>> hdl/ehbp_host_port.sv
// Host bus port: SRAM-like 16-bit slave in front of 32-bit data paths.
// Assumes strobes are synchronous to mclk and each lasts two cycles or more.
// Behaviour
// - Data moves as 16-bit transfers on a shared bus, host writes and reads.
// - Internal paths are 32 bits; two host halves form one word.
// - A 7-bit word address selects own registers, MAC registers or FIFOs.
// - Strobes count only while chip select is low.
// - A chip-selected write strobe ends reduced power.
// - With FIFO select high all accesses go to data FIFOs, upper address ignored.
// - Acts like asynchronous SRAM, no wait or ready handshake to the host.
// - Byte order is configurable for big- and little-endian hosts.
// - One interrupt output combines the enabled sources.
// - Interrupt polarity, sources and push-pull or open-drain are programmable.
// - After deassertion the interrupt is held off for a programmed interval.
// - A separate wake event output rises on a detected wakeup.
// - MAC transmit buffer holds 2K bytes; transmission starts after whole frame.
// - Receive data passes a 128-byte MAC buffer, host reads only the FIFO.
// - The host has no path into MAC-internal buffers.
// - Separate transmit and receive paths carry data and status.
// - MAC registers sit on a third internal bus reachable from the host.
// - PHY registers are reached through MAC registers and management bus.
`timescale 1ns/1ps
`default_nettype none
module ehbp_host_port (
   input  wire logic        mclk,
   input  wire logic        arst_n,
   // Host pins
   input  wire logic [6:0]  hostAddr,
   input  wire logic [15:0] hostDataIn,
   output logic [15:0]      hostDataOut,
   output logic             hostDataOe,
   input  wire logic        read_strobe_n,
   input  wire logic        write_strobe_n,
   input  wire logic        chip_select_n,
   input  wire logic        fifoSel,
   output logic             irqOut,
   output logic             irqOe,
   output logic             wake_event_output,
   // Receive FIFO side
   input  wire logic [31:0] rxWord,
   input  wire logic        rxValid,
   output logic             rxReady,
   // Transmit FIFO side toward the MAC interface layer
   output logic [31:0]      txWord,
   output logic             txValid,
   input  wire logic        txReady,
   output logic             txStart,
   // MAC register bus
   output logic [6:0]       macAddr,
   output logic [31:0]      macWdata,
   output logic             macWrite,
   output logic             macRead,
   input  wire logic [31:0] macRdata,
   input  wire logic        macIrq,
   input  wire logic        wakeDetect,
   output logic             lowPower
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   logic        rdPrev_r;
   logic        wrActive_r;
   logic [6:0]  wrAddr_r;
   logic [15:0] wrData_r;
   logic        wrFifo_r;
   logic [15:0] ctrl_r;
   logic [3:0]  irqEn_r;
   logic [3:0]  irqSts_r;
   logic [7:0]  holdoff_r;
   logic        txHalf_r;
   logic [15:0] txLow_r;
   logic        rxHalf_r;
   logic [31:0] macHold_r;
   logic [31:0] macWlo_r;
   logic        macRdPend_r;
   logic        macRdHigh_r;
   logic [12:0] txBytes_r;
   logic        eofPend_r;
   logic [15:0] hostDataOut_r;
   logic        hostDataOe_r;
   logic        irqOut_r;
   logic        irqOe_r;
   logic        irqAct_r;
   logic [11:0] unitCnt_r;
   logic [7:0]  holdCnt_r;
   logic        wake_r;
   logic [6:0]  macAddr_r;
   logic [31:0] macWdata_r;
   logic        macWrite_r;
   logic        macRead_r;
   logic        txStart_r;

   // ---------------------------------------------------------------
   // Strobe qualification and decode
   // ---------------------------------------------------------------
   logic rdLevel;
   logic wrLevel;
   logic rdStart;
   logic wrEnd;
   logic rdData;
   logic rdMac;
   logic wrMac;
   logic wrOwn;
   // Strobes only count with chip select low
   assign rdLevel = ~chip_select_n & ~read_strobe_n;
   assign wrLevel = ~chip_select_n & ~write_strobe_n;
   assign rdStart = rdLevel & ~rdPrev_r;
   // Write data taken at strobe release, like SRAM; no ready back to the host
   assign wrEnd   = wrActive_r & ~wrLevel;
   assign rdData  = fifoSel | (hostAddr[6:5] == 2'b00);
   assign rdMac   = ~rdData & (hostAddr >= ehbp_pkg::ADDR_MAC_LO);
   assign wrMac   = ~wrFifo_r & (wrAddr_r >= ehbp_pkg::ADDR_MAC_LO);
   assign wrOwn   = ~wrFifo_r & ~wrMac;

   // ---------------------------------------------------------------
   // Data buffers on both paths
   // ---------------------------------------------------------------
   logic [31:0] rxHead;
   logic        rxHeadValid;
   logic        rxPop;
   logic [31:0] txIn;
   logic        txPush;
   logic        txInReady;
   logic [31:0] rxSwap;
   logic [31:0] txSwap;
   logic        bigEnd;

   assign bigEnd = ctrl_r[ehbp_pkg::CTRL_BIG_END];
   // Byte reversal serves big-endian hosts on both directions
   assign rxSwap = bigEnd ? {rxHead[7:0], rxHead[15:8], rxHead[23:16], rxHead[31:24]} : rxHead;
   assign txIn   = {wrData_r, txLow_r};
   assign txSwap = bigEnd ? {txIn[7:0], txIn[15:8], txIn[23:16], txIn[31:24]} : txIn;
   // Pop as the second half read starts, push after the second half write ends
   assign rxPop  = rdStart & rdData & rxHalf_r & rxHeadValid;
   assign txPush = wrEnd & wrFifo_r & txHalf_r;

   // Receive and transmit are separate paths
   ehbp_skid_buf #(.W(ehbp_pkg::WORD_W)) rxBuf (
      .mclk     (mclk),
      .arst_n   (arst_n),
      .inData   (rxWord),
      .inValid  (rxValid),
      .inReady  (rxReady),
      .outData  (rxHead),
      .outValid (rxHeadValid),
      .outReady (rxPop)
   );

   ehbp_skid_buf #(.W(ehbp_pkg::WORD_W)) txBuf (
      .mclk     (mclk),
      .arst_n   (arst_n),
      .inData   (txSwap),
      .inValid  (txPush),
      .inReady  (txInReady),
      .outData  (txWord),
      .outValid (txValid),
      .outReady (txReady)
   );

   // ---------------------------------------------------------------
   // Read mux; MAC buffers are absent from it on purpose
   // ---------------------------------------------------------------
   logic [15:0] ownRd;
   logic [15:0] statusWord;
   logic [15:0] rdMux;
   assign statusWord = {10'h000, eofPend_r, lowPower, txHalf_r, rxHalf_r, txInReady, rxHeadValid};
   assign ownRd = (hostAddr == ehbp_pkg::ADDR_CTRL)    ? ctrl_r :
                  (hostAddr == ehbp_pkg::ADDR_IRQ_EN)  ? {12'h000, irqEn_r} :
                  (hostAddr == ehbp_pkg::ADDR_IRQ_STS) ? {12'h000, irqSts_r} :
                  (hostAddr == ehbp_pkg::ADDR_HOLDOFF) ? {8'h00, holdoff_r} :
                  (hostAddr == ehbp_pkg::ADDR_STATUS)  ? statusWord : 16'h0000;
   // No path into the MAC-internal buffers exists here
   assign rdMux = rdData ? (rxHeadValid ? (rxHalf_r ? rxSwap[31:16] : rxSwap[15:0]) : 16'h0000)
                : rdMac ? (hostAddr[0] ? macHold_r[31:16] : 16'h0000) : ownRd;

   // ---------------------------------------------------------------
   // Host cycle tracking
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rdPrev_r   <= 1'b0;
         wrActive_r <= 1'b0;
         wrAddr_r   <= 7'h00;
         wrData_r   <= 16'h0000;
         wrFifo_r   <= 1'b0;
      end else begin
         rdPrev_r   <= rdLevel;
         wrActive_r <= wrLevel;
         if (wrLevel) begin
            wrAddr_r <= hostAddr;
            wrData_r <= hostDataIn;
            wrFifo_r <= fifoSel | (hostAddr[6:5] == 2'b00);
         end
      end
   end

   // Host-facing bus drive, one cycle behind the strobe
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         hostDataOut_r <= 16'h0000;
         hostDataOe_r  <= 1'b0;
      end else begin
         hostDataOe_r <= rdLevel;
         if (rdStart) begin
            hostDataOut_r <= rdMux;
         end else if (macRdPend_r) begin
            // Held copy: the register bus data is only valid with its strobe
            hostDataOut_r <= macRdHigh_r ? macHold_r[31:16] : macHold_r[15:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // Half pairing for FIFO words
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rxHalf_r <= 1'b0;
         txHalf_r <= 1'b0;
         txLow_r  <= 16'h0000;
      end else begin
         if (rdStart && rdData && rxHeadValid) begin
            rxHalf_r <= ~rxHalf_r;
         end
         if (wrEnd && wrFifo_r) begin
            txHalf_r <= ~txHalf_r;
            if (!txHalf_r) begin
               txLow_r <= wrData_r;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Own registers and power state
   // ---------------------------------------------------------------
   logic [3:0] srcEvt;
   logic [3:0] stsClr;
   assign srcEvt = {macIrq, rdStart & rdData & ~rxHeadValid, txPush & ~txInReady, rxHeadValid};
   assign stsClr = (wrEnd && wrOwn && wrAddr_r == ehbp_pkg::ADDR_IRQ_STS) ? wrData_r[3:0] : 4'h0;

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_r    <= ehbp_pkg::CTRL_RST;
         irqEn_r   <= ehbp_pkg::IRQ_EN_RST;
         holdoff_r <= ehbp_pkg::HOLDOFF_RST;
         irqSts_r  <= 4'h0;
      end else begin
         if (wrEnd && wrOwn && wrAddr_r == ehbp_pkg::ADDR_CTRL) begin
            ctrl_r <= wrData_r;
         end else if (wrLevel) begin
            ctrl_r[ehbp_pkg::CTRL_LOW_PWR] <= 1'b0;
         end
         if (wrEnd && wrOwn && wrAddr_r == ehbp_pkg::ADDR_IRQ_EN) begin
            irqEn_r <= wrData_r[3:0];
         end
         if (wrEnd && wrOwn && wrAddr_r == ehbp_pkg::ADDR_HOLDOFF) begin
            holdoff_r <= wrData_r[7:0];
         end
         // New event beats a clear in the same cycle
         irqSts_r <= (irqSts_r & ~stsClr) | srcEvt;
      end
   end

   // Wake flag rises only while in reduced power
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         wake_r <= 1'b0;
      end else begin
         wake_r <= lowPower & (wake_r | wakeDetect);
      end
   end

   // ---------------------------------------------------------------
   // Interrupt with holdoff
   // ---------------------------------------------------------------
   logic irqWant;
   logic unitTick;
   logic irqGo;
   assign irqWant  = |(irqSts_r & irqEn_r);
   assign unitTick = (unitCnt_r == 12'(ehbp_pkg::HOLDOFF_UNIT_CYC - 1));
   assign irqGo    = irqWant & (holdCnt_r == 8'h00);

   // Holdoff counts in unit ticks so the count stays narrow
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         unitCnt_r <= 12'h000;
         holdCnt_r <= 8'h00;
         irqAct_r  <= 1'b0;
      end else begin
         unitCnt_r <= unitTick ? 12'h000 : unitCnt_r + 12'h001;
         irqAct_r  <= irqGo | (irqAct_r & irqWant);
         if (irqAct_r && !irqWant) begin
            holdCnt_r <= holdoff_r;
         end else if (unitTick && holdCnt_r != 8'h00) begin
            holdCnt_r <= holdCnt_r - 8'h01;
         end
      end
   end

   // Open-drain only pulls low, so sharing never fights
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         irqOut_r <= 1'b0;
         irqOe_r  <= 1'b0;
      end else begin
         if (ctrl_r[ehbp_pkg::CTRL_IRQ_PP]) begin
            irqOut_r <= irqAct_r ~^ ctrl_r[ehbp_pkg::CTRL_IRQ_POL];
            irqOe_r  <= 1'b1;
         end else begin
            irqOut_r <= 1'b0;
            irqOe_r  <= irqAct_r;
         end
      end
   end

   // ---------------------------------------------------------------
   // MAC register bus, 32-bit words from half pairs
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         macAddr_r   <= 7'h00;
         macWdata_r  <= 32'h00000000;
         macWrite_r  <= 1'b0;
         macRead_r   <= 1'b0;
         macRdPend_r <= 1'b0;
         macRdHigh_r <= 1'b0;
         macHold_r   <= 32'h00000000;
         macWlo_r    <= 32'h00000000;
      end else begin
         macWrite_r  <= 1'b0;
         macRead_r   <= 1'b0;
         macRdPend_r <= macRead_r;
         if (wrEnd && wrMac && !wrAddr_r[0]) begin
            macWlo_r <= {16'h0000, wrData_r};
         end else if (wrEnd && wrMac) begin
            macAddr_r  <= {wrAddr_r[6:1], 1'b0};
            macWdata_r <= {wrData_r, macWlo_r[15:0]};
            macWrite_r <= 1'b1;
         end else if (rdStart && rdMac && !hostAddr[0]) begin
            macAddr_r   <= hostAddr;
            macRead_r   <= 1'b1;
            macRdHigh_r <= 1'b0;
         end
         if (macRead_r) begin
            macHold_r <= macRdata;
         end
      end
   end

   // ---------------------------------------------------------------
   // Store-and-forward frame release toward the MAC
   // ---------------------------------------------------------------
   logic txMove;
   assign txMove = txValid & txReady;
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         txBytes_r <= 13'h0000;
         eofPend_r <= 1'b0;
         txStart_r <= 1'b0;
      end else begin
         txStart_r <= eofPend_r & ~txValid & ~txStart_r & (txBytes_r != 13'h0000);
         if (txStart_r) begin
            txBytes_r <= 13'h0000;
            eofPend_r <= 1'b0;
         end else if (txMove && txBytes_r < 13'(ehbp_pkg::MAC_TX_BYTES)) begin
            txBytes_r <= txBytes_r + ehbp_pkg::TX_BYTES_PER_WORD;
         end
         // A frame end in the clearing cycle still counts
         if (wrEnd && wrOwn && wrAddr_r == ehbp_pkg::ADDR_TX_CMD) begin
            eofPend_r <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign hostDataOut       = hostDataOut_r;
   assign hostDataOe        = hostDataOe_r;
   assign irqOut            = irqOut_r;
   assign irqOe             = irqOe_r;
   assign wake_event_output = wake_r;
   assign macAddr           = macAddr_r;
   assign macWdata          = macWdata_r;
   assign macWrite          = macWrite_r;
   assign macRead           = macRead_r;
   assign txStart           = txStart_r;
   assign lowPower          = ctrl_r[ehbp_pkg::CTRL_LOW_PWR];
endmodule : ehbp_host_port
`default_nettype wire

// >>> bench/ehbp_port_chk.sv
// Concurrent checks on the pins of the host bus port.
// Assumes one clock domain; bound to every instance of the port.
`timescale 1ns/1ps
`default_nettype none
// ------
// Checker
// ------
module ehbp_port_chk (
   input wire logic        mclk,
   input wire logic        arst_n,
   input wire logic        read_strobe_n,
   input wire logic        write_strobe_n,
   input wire logic        chip_select_n,
   input wire logic        fifoSel,
   input wire logic        hostDataOe,
   input wire logic        irqOut,
   input wire logic        irqOe,
   input wire logic        wake_event_output,
   input wire logic        lowPower,
   input wire logic        txStart,
   input wire logic        txValid,
   input wire logic        txReady,
   input wire logic [31:0] txWord,
   input wire logic        macWrite,
   input wire logic        macRead
);
   // All checks share the device clock and its reset
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   a_oe_on_read: assert property (!chip_select_n && !read_strobe_n |=> hostDataOe)
      else $error("bus not driven during read");
   a_oe_needs_cs: assert property (chip_select_n |=> !hostDataOe)
      else $error("bus driven without chip select");
   a_write_wakes: assert property (lowPower && !chip_select_n && !write_strobe_n |-> ##[1:6] !lowPower)
      else $error("write strobe left low power");
   a_wake_in_low: assert property ($rose(wake_event_output) |-> $past(lowPower))
      else $error("wake event outside low power");
   a_od_quiet: assert property (!irqOe |-> !irqOut)
      else $error("interrupt pin level while released");
   a_start_pulse: assert property (txStart |=> !txStart)
      else $error("frame start longer than one cycle");
   a_mac_pulse: assert property (macRead || macWrite |=> !macRead && !macWrite)
      else $error("register bus strobe too long");
   a_tx_hold: assert property (txValid && !txReady |=> txValid && $stable(txWord))
      else $error("stalled transmit word changed");
   a_fifo_no_mac: assert property (fifoSel && !chip_select_n && !read_strobe_n |-> ##2 !macRead)
      else $error("data port read reached register bus");
   // Main scenarios reached
   c_start: cover property (txStart);
   c_stall: cover property (txValid && !txReady);
   c_wake: cover property ($rose(lowPower) ##[1:200] $fell(lowPower));
endmodule : ehbp_port_chk
bind ehbp_host_port ehbp_port_chk chk (.*);
`default_nettype wire

// >>> bench/ehbp_far_model.sv
// Model of the FIFO and MAC side behind the host bus port.
// Assumes the port's valid/ready and one-cycle register strobes.
`timescale 1ns/1ps
`default_nettype none
module ehbp_far_model (
   input wire logic        mclk,
   input wire logic        arst_n,
   output logic [31:0]     rxWord,
   output logic            rxValid,
   input wire logic        rxReady,
   input wire logic [31:0] txWord,
   input wire logic        txValid,
   output logic            txReady,
   input wire logic        stallTx,
   input wire logic [31:0] macWdata,
   input wire logic        macWrite,
   input wire logic        macRead,
   output logic [31:0]     macRdata,
   output logic [31:0]     txLast,
   output logic [7:0]      txCount
);
   logic [7:0]  rxCnt_r;
   logic [31:0] macReg_r;
   // Receive side always has a word; stall on transmit is bench driven
   assign rxValid = 1'b1;
   assign rxWord = 32'ha1b2c3d4 + {24'h0, rxCnt_r};
   assign txReady = !stallTx;
   // Read data is junk outside the strobe so a late sample shows
   assign macRdata = macRead ? macReg_r : ~macReg_r;
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rxCnt_r <= 8'h00;
         macReg_r <= 32'h00000000;
         txLast <= 32'h00000000;
         txCount <= 8'h00;
      end else begin
         if (rxValid && rxReady) rxCnt_r <= rxCnt_r + 8'h01;
         if (macWrite) macReg_r <= macWdata;
         if (txValid && txReady) txLast <= txWord;
         if (txValid && txReady) txCount <= txCount + 8'h01;
      end
   end
endmodule : ehbp_far_model
`default_nettype wire

// >>> bench/test_ethernet_host_bus_port.sv
// Self-checking bench for the host bus port with its far side model.
// Assumes host strobes driven at the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module test_ethernet_host_bus_port;
   logic mclk = 1'b0, arst_n = 1'b0, chip_select_n = 1'b1, read_strobe_n = 1'b1;
   logic write_strobe_n = 1'b1, fifoSel = 1'b0, macIrq = 1'b0, wakeDetect = 1'b0, stallTx = 1'b0;
   logic [6:0] hostAddr = 7'h00, macAddr;
   logic [15:0] hostDataIn = 16'h0000, hostDataOut, rdv;
   logic hostDataOe, irqOut, irqOe, wake_event_output, rxValid, rxReady, txValid, txReady;
   logic txStart, macWrite, macRead, lowPower, ok;
   logic [31:0] rxWord, txWord, macWdata, macRdata, txLast;
   logic [7:0] txCount;
   int miscompares = 0, n_compared = 0;
   always #12.5 mclk = ~mclk;
   ehbp_host_port uut (.*);
   ehbp_far_model far (.*);
   // ------
   // Host access tasks
   // ------
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask : cyc
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      hostAddr = a;
      hostDataIn = d;
      chip_select_n = 1'b0;
      write_strobe_n = 1'b0;
      cyc(2);
      chip_select_n = 1'b1;
      write_strobe_n = 1'b1;
      cyc(2);
   endtask : wr
   // Held four cycles so even the slow register bus path has answered
   task automatic rchk(input logic [6:0] a, input logic fs, input logic [15:0] e);
      hostAddr = a;
      fifoSel = fs;
      chip_select_n = 1'b0;
      read_strobe_n = 1'b0;
      cyc(4);
      chip_select_n = 1'b1;
      read_strobe_n = 1'b1;
      cyc(1);
      fifoSel = 1'b0;
      chk({16'h0000, hostDataOut}, {16'h0000, e});
   endtask : rchk
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   // Bounded poll at falling edges, so a one-cycle pulse is not missed
   task automatic poll(input logic sel);
      ok = 1'b0;
      for (int i = 0; i < 50 && !ok; i++) begin
         ok = sel ? wake_event_output : txStart;
         if (!ok) @(negedge mclk);
      end
      if (!ok) begin
         miscompares++;
         report_and_stop();
      end
   endtask : poll
   task automatic report_and_stop;
      $display("compared=%0d mismatches=%0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : report_and_stop
   // ------
   // Scenarios
   // ------
   initial begin
      cyc(2);
      arst_n = 1'b1;
      cyc(1);
      rchk(7'h20, 1'b0, 16'h0000);
      rchk(7'h21, 1'b0, 16'h0000);
      rchk(7'h7f, 1'b1, 16'hc3d4);
      rchk(7'h7f, 1'b1, 16'ha1b2);
      wr(7'h20, 16'h0001);
      rchk(7'h05, 1'b0, 16'hb2a1);
      rchk(7'h05, 1'b0, 16'hd5c3);
      wr(7'h20, 16'h0000);
      // Stalled receiver must not lose the pushed word
      stallTx = 1'b1;
      wr(7'h00, 16'h5678);
      wr(7'h00, 16'h1234);
      chk({31'h0, txValid}, 32'h1);
      chk({24'h0, txCount}, 32'h0);
      stallTx = 1'b0;
      wr(7'h24, 16'h0001);
      poll(1'b0);
      chk(txLast, 32'h12345678);
      chk({24'h0, txCount}, 32'h1);
      wr(7'h28, 16'hbeef);
      wr(7'h29, 16'hdead);
      rchk(7'h28, 1'b0, 16'hbeef);
      rchk(7'h29, 1'b0, 16'hdead);
      chk({25'h0, macAddr}, 32'h28);
      wr(7'h20, 16'h0008);
      chk({31'h0, lowPower}, 32'h1);
      wakeDetect = 1'b1;
      poll(1'b1);
      wakeDetect = 1'b0;
      // Two holdoff units: at least one full unit of silence
      wr(7'h23, 16'h0002);
      chk({30'h0, lowPower, wake_event_output}, 32'h0);
      // Source masked first, then enabled in both pin modes
      macIrq = 1'b1;
      cyc(4);
      chk({30'h0, irqOe, irqOut}, 32'h0);
      wr(7'h21, 16'h0008);
      cyc(1);
      chk({30'h0, irqOe, irqOut}, 32'h2);
      wr(7'h20, 16'h0006);
      chk({30'h0, irqOe, irqOut}, 32'h3);
      macIrq = 1'b0;
      wr(7'h22, 16'h0008);
      cyc(2);
      chk({30'h0, irqOe, irqOut}, 32'h2);
      // Source back at once: held off, then released
      macIrq = 1'b1;
      cyc(4);
      chk({30'h0, irqOe, irqOut}, 32'h2);
      cyc(810);
      chk({30'h0, irqOe, irqOut}, 32'h3);
      report_and_stop();
   end
endmodule : test_ethernet_host_bus_port
`default_nettype wire
